//--- hdl/erl_defs.vh
/*
  Constants of the event response and log state unit: register offsets,
  field positions, reset values, state codes and timing counts.
  Assumes inclusion by bare name from the unit's design file.
*/
`ifndef ERL_DEFS_VH
`define ERL_DEFS_VH

`define ERL_NUM_EVT      8
`define ERL_NUM_MOD      7
`define ERL_NUM_RLY      4

// Register byte offsets
`define ERL_A_STATUS     12'h000
`define ERL_A_RESET      12'h004
`define ERL_A_STATES     12'h008
`define ERL_A_CFG_SEL    12'h00c
`define ERL_A_CFG_DATA   12'h010
`define ERL_A_TIMING     12'h014
`define ERL_A_RLY_MAP    12'h018
`define ERL_A_LOG_VIS    12'h01c

// Response bits of one configuration byte
`define ERL_R_WARN       0
`define ERL_R_HORN       1
`define ERL_R_SOFT       2
`define ERL_R_HARD       3
`define ERL_R_BRK1       4
`define ERL_R_BRK2       5
`define ERL_R_FPT        6
`define ERL_R_ACTONLY    7

// Select register fields
`define ERL_SEL_EDIT     8

// Per-event allowed response masks and reset configurations, event 7 down to event 0
`define ERL_ALLOWED      64'hff_ff_ff_ff_fe_fe_c3_c3
`define ERL_CFG_RST      64'h00_00_00_00_0c_0c_43_43

// Event states
`define ERL_S_NONE       2'h0
`define ERL_S_PRESENT    2'h1
`define ERL_S_ACTIVE     2'h2
`define ERL_S_INACTIVE   2'h3

// Relay functions
`define ERL_F_OFF        2'h0
`define ERL_F_HORN       2'h1
`define ERL_F_BRK1       2'h2
`define ERL_F_BRK2       2'h3

// Timing
`define ERL_CLK_HZ       25000000
`define ERL_TICK_S       1
`define ERL_TICK_CYCLES  (`ERL_CLK_HZ * `ERL_TICK_S)
`define ERL_TIMING_RST   16'h0a_05

`endif

//--- hdl/erl_event_unit.v
/*
  Event response and log state unit of a generator set controller.
  Tracks locally generated events, applies their configured responses
  and reports which module logs are visible, all behind an APB slave.
  Assumes synchronous inputs on CLOCK and a synchronous active-high RESET.
*/
// Added by the designer: the APB register port and the register addresses.
`include "erl_defs.vh"

// Notes on behaviour
// (R1) Each local event entry is present, active or inactive, nothing else.
// (R2) While its condition holds an event stays present and resets are refused.
// (R3) A cleared non-warning event latches active and inhibits restart until reset; here only soft or hard shutdown events latch.
// (R4) Warning events go present to inactive on clearing, never active.
// (R5) Inactive entries are history only, with no effect on outputs.
// (R6) Response configuration is editable only in stop mode; view is default.
// (R7) Warning response logs a warning and lights amber, engine keeps running.
// (R8) Audible alert drives every horn-assigned output; none assigned means nothing.
// (R9) Audible alert is refused unless warning or shutdown is also enabled.
// (R10) Soft shutdown logs, lights red, stops engine after cooldown expires.
// (R11) Immediate_stop_response logs, stops engine at once, lights red.
// (R12) Two breaker trips each drive their own signal to assigned outputs.
// (R13) Fault-protection gated events are suppressed unless running and timer expired.
// (R14) Active-only events log informationally and vanish when condition clears; here those with soft or hard shutdown latch active.
// (R15) Each event accepts only its own allowed subset of responses.
// (R16) A module log is visible only when attached and communicating.
// (R17) The local log stores only locally generated events.
// (R18) External modules refuse reset-all while the cause persists.
// (R19) Fault protection timer starts at crank terminate, expires after its delay.
// (R20) Event resets are honoured only in stop mode.
// (R21) An accepted reset moves an active event to inactive, freeing restart.
module erl_event_unit #(
  parameter TICK_CYCLES = `ERL_TICK_CYCLES
) (
  // Clock and reset
  input  wire        CLOCK,
  input  wire        RESET,
  // APB slave
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [11:0] PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  // Engine and condition inputs
  input  wire [7:0]  EVENT_COND,
  input  wire        ENGINE_CONTROL_SWITCH_STOP,
  input  wire        ENGINE_RUNNING,
  input  wire        CRANK_TERMINATE,
  // Expansion modules on the data links
  input  wire [6:0]  MODULE_ATTACHED,
  input  wire [6:0]  MODULE_COMMUNICATING,
  // Indicators and actuators
  output reg         AMBER_LED,
  output reg         RED_LED,
  output reg  [3:0]  RELAY_OUT,
  output reg         ENGINE_STOP,
  output reg         RESTART_INHIBIT,
  output reg         BREAKER1_TRIP,
  output reg         BREAKER2_TRIP,
  output reg  [6:0]  LOG_VISIBLE
);

  localparam [31:0] TICK_LAST_W = TICK_CYCLES - 1;
  localparam [24:0] TICK_LAST   = TICK_LAST_W[24:0];

  reg  [15:0] state_q;
  reg  [63:0] cfg_q;
  reg  [8:0]  sel_q;
  reg  [15:0] timing_q;
  reg  [7:0]  rly_map_q;
  reg  [24:0] tick_cnt_q;
  reg         tick_q;
  reg  [7:0]  fpt_cnt_q;
  reg         fpt_run_q;
  reg         fpt_done_q;
  reg         crank_q;
  reg  [7:0]  cool_cnt_q;
  reg         cool_run_q;
  reg         reset_refused_q;
  reg         cfg_rejected_q;

  reg  [15:0] state_d;
  reg  [7:0]  qual;
  reg  [7:0]  rst_req;
  reg         any_warn;
  reg         any_horn;
  reg         any_soft;
  reg         any_hard;
  reg         any_brk1;
  reg         any_brk2;
  reg         any_active;
  reg         any_shut;
  reg  [7:0]  c;
  reg  [1:0]  s;
  integer     i;
  integer     j;
  integer     k;

  wire        setup   = PSEL & ~PENABLE;
  wire        wr_acc  = PSEL & PENABLE & PREADY & PWRITE;
  wire [2:0]  sel_idx = sel_q[2:0];
  wire [7:0]  cfg_sel = cfg_q[sel_idx*8 +: 8];
  wire [63:0] allow_all = `ERL_ALLOWED >> {sel_idx, 3'h0};
  wire [7:0]  allow   = allow_all[7:0];

  // An event in force affects the engine; inactive ones never do
  function in_force;
    input [1:0] st;
    begin
      in_force = (st == `ERL_S_PRESENT) || (st == `ERL_S_ACTIVE); // R5
    end
  endfunction

  function mapped;
    input [11:0] a;
    begin
      mapped = (a[1:0] == 2'h0) && (a[11:5] == 7'h00);
    end
  endfunction

  // Event state machines and response gathering
  always @* begin
    state_d    = state_q;
    qual       = 8'h00;
    rst_req    = 8'h00;
    any_warn   = 1'b0;
    any_horn   = 1'b0;
    any_soft   = 1'b0;
    any_hard   = 1'b0;
    any_brk1   = 1'b0;
    any_brk2   = 1'b0;
    any_active = 1'b0;
    c          = 8'h00;
    s          = `ERL_S_NONE;
    if (wr_acc && PADDR == `ERL_A_RESET && ENGINE_CONTROL_SWITCH_STOP) begin
      rst_req = PWDATA[7:0]; // R20
    end
    for (i = 0; i < `ERL_NUM_EVT; i = i + 1) begin
      c = cfg_q[i*8 +: 8];
      s = state_q[i*2 +: 2];
      qual[i] = EVENT_COND[i] &
                (~c[`ERL_R_FPT] | (ENGINE_RUNNING & fpt_done_q)); // R13
      case (s)
        `ERL_S_NONE, `ERL_S_INACTIVE: begin
          if (qual[i]) begin
            state_d[i*2 +: 2] = `ERL_S_PRESENT; // R1
          end
        end
        `ERL_S_PRESENT: begin
          if (!qual[i]) begin // R2
            if (c[`ERL_R_ACTONLY] && !(c[`ERL_R_SOFT] | c[`ERL_R_HARD])) begin
              state_d[i*2 +: 2] = `ERL_S_NONE; // R14
            end else if (c[`ERL_R_SOFT] | c[`ERL_R_HARD]) begin
              state_d[i*2 +: 2] = `ERL_S_ACTIVE; // R3
            end else begin
              state_d[i*2 +: 2] = `ERL_S_INACTIVE; // R4
            end
          end
        end
        `ERL_S_ACTIVE: begin
          if (qual[i]) begin
            state_d[i*2 +: 2] = `ERL_S_PRESENT;
          end else if (rst_req[i]) begin
            state_d[i*2 +: 2] = `ERL_S_INACTIVE; // R21
          end
        end
        default: begin
          state_d[i*2 +: 2] = `ERL_S_NONE;
        end
      endcase
      if (in_force(s)) begin
        any_warn = any_warn | (c[`ERL_R_WARN] & (s == `ERL_S_PRESENT)); // R7
        any_horn = any_horn | (c[`ERL_R_HORN] & (s == `ERL_S_PRESENT)); // R8
        any_soft = any_soft | c[`ERL_R_SOFT]; // R10
        any_hard = any_hard | c[`ERL_R_HARD]; // R11
        any_brk1 = any_brk1 | c[`ERL_R_BRK1]; // R12
        any_brk2 = any_brk2 | c[`ERL_R_BRK2]; // R12
      end
      any_active = any_active | (s == `ERL_S_ACTIVE); // R3
    end
    any_shut = any_soft | any_hard;
  end

  // One-second tick, the only slow rate in the block
  always @(posedge CLOCK) begin
    if (RESET) begin
      tick_cnt_q <= 25'h0000000;
      tick_q     <= 1'b0;
    end else begin
      tick_q <= (tick_cnt_q == TICK_LAST);
      if (tick_cnt_q == TICK_LAST) begin
        tick_cnt_q <= 25'h0000000;
      end else begin
        tick_cnt_q <= tick_cnt_q + 25'h0000001;
      end
    end
  end

  // Fault protection timer and cooldown
  always @(posedge CLOCK) begin
    if (RESET) begin
      crank_q    <= 1'b0;
      fpt_run_q  <= 1'b0;
      fpt_done_q <= 1'b0;
      fpt_cnt_q  <= 8'h00;
      cool_run_q <= 1'b0;
      cool_cnt_q <= 8'h00;
    end else begin
      crank_q <= CRANK_TERMINATE;
      if (!ENGINE_RUNNING) begin
        fpt_run_q  <= 1'b0;
        fpt_done_q <= 1'b0;
      end else if (CRANK_TERMINATE && !crank_q && !fpt_run_q && !fpt_done_q) begin
        fpt_run_q <= 1'b1; // R19
        fpt_cnt_q <= timing_q[15:8];
      end else if (fpt_run_q && tick_q) begin
        if (fpt_cnt_q <= 8'h01) begin
          fpt_run_q  <= 1'b0;
          fpt_done_q <= 1'b1; // R19
        end else begin
          fpt_cnt_q <= fpt_cnt_q - 8'h01;
        end
      end
      // Cooldown is dropped if the shutdown cause goes away first
      if (!any_soft || any_hard) begin
        cool_run_q <= 1'b0;
      end else if (!cool_run_q && !ENGINE_STOP) begin
        cool_run_q <= 1'b1; // R10
        cool_cnt_q <= timing_q[7:0];
      end else if (cool_run_q && tick_q && cool_cnt_q != 8'h00) begin
        cool_cnt_q <= cool_cnt_q - 8'h01;
      end
    end
  end

  // Outputs, all registered
  always @(posedge CLOCK) begin
    if (RESET) begin
      AMBER_LED       <= 1'b0;
      RED_LED         <= 1'b0;
      RELAY_OUT       <= 4'h0;
      ENGINE_STOP     <= 1'b0;
      RESTART_INHIBIT <= 1'b0;
      BREAKER1_TRIP   <= 1'b0;
      BREAKER2_TRIP   <= 1'b0;
      LOG_VISIBLE     <= 7'h00;
    end else begin
      AMBER_LED       <= any_warn; // R7
      RED_LED         <= any_shut; // R10 R11
      RESTART_INHIBIT <= any_active | any_shut; // R3
      BREAKER1_TRIP   <= any_brk1; // R12
      BREAKER2_TRIP   <= any_brk2; // R12
      if (!any_shut) begin
        ENGINE_STOP <= 1'b0;
      end else if (any_hard) begin
        ENGINE_STOP <= 1'b1; // R11
      end else if (cool_run_q && cool_cnt_q == 8'h00) begin
        ENGINE_STOP <= 1'b1; // R10
      end
      for (j = 0; j < `ERL_NUM_RLY; j = j + 1) begin
        case (rly_map_q[j*2 +: 2])
          `ERL_F_HORN: RELAY_OUT[j] <= any_horn; // R8
          `ERL_F_BRK1: RELAY_OUT[j] <= any_brk1; // R12
          `ERL_F_BRK2: RELAY_OUT[j] <= any_brk2; // R12
          default:     RELAY_OUT[j] <= 1'b0;
        endcase
      end
      // Local log only ever holds this unit's own events
      LOG_VISIBLE <= MODULE_ATTACHED & MODULE_COMMUNICATING; // R16 R17
    end
  end

  // Register file and event states
  always @(posedge CLOCK) begin
    if (RESET) begin
      state_q         <= 16'h0000;
      cfg_q           <= `ERL_CFG_RST;
      sel_q           <= 9'h000;
      timing_q        <= `ERL_TIMING_RST;
      rly_map_q       <= 8'h00;
      reset_refused_q <= 1'b0;
      cfg_rejected_q  <= 1'b0;
      PRDATA          <= 32'h00000000;
      PREADY          <= 1'b0;
      PSLVERR         <= 1'b0;
    end else begin
      state_q <= state_d;
      // No wait state; read data is registered during the setup cycle
      PREADY  <= setup;
      PSLVERR <= setup & ~mapped(PADDR);
      if (setup) begin
        case (PADDR)
          `ERL_A_STATUS:   PRDATA <= {26'h0, cfg_rejected_q, reset_refused_q,
                                      cool_run_q, fpt_done_q, fpt_run_q,
                                      ENGINE_CONTROL_SWITCH_STOP};
          `ERL_A_STATES:   PRDATA <= {16'h0000, state_q};
          `ERL_A_CFG_SEL:  PRDATA <= {23'h000000, sel_q};
          `ERL_A_CFG_DATA: PRDATA <= {16'h0000, allow, cfg_sel};
          `ERL_A_TIMING:   PRDATA <= {16'h0000, timing_q};
          `ERL_A_RLY_MAP:  PRDATA <= {24'h000000, rly_map_q};
          `ERL_A_LOG_VIS:  PRDATA <= {25'h0000000, LOG_VISIBLE};
          default:         PRDATA <= 32'h00000000;
        endcase
      end
      if (wr_acc) begin
        case (PADDR)
          `ERL_A_STATUS: begin
            // Sticky flags: write one to clear
            reset_refused_q <= reset_refused_q & ~PWDATA[4];
            cfg_rejected_q  <= cfg_rejected_q & ~PWDATA[5];
          end
          `ERL_A_RESET: begin
            for (k = 0; k < `ERL_NUM_EVT; k = k + 1) begin
              if (PWDATA[k] && (state_q[k*2 +: 2] == `ERL_S_PRESENT ||
                  !ENGINE_CONTROL_SWITCH_STOP)) begin
                reset_refused_q <= 1'b1; // R2 R20
              end
            end
          end
          `ERL_A_CFG_SEL: sel_q <= {PWDATA[`ERL_SEL_EDIT], 5'h00, PWDATA[2:0]}; // R6
          `ERL_A_CFG_DATA: begin
            if (!ENGINE_CONTROL_SWITCH_STOP || !sel_q[`ERL_SEL_EDIT]) begin
              cfg_rejected_q <= 1'b1; // R6
            end else if ((PWDATA[7:0] & ~allow) != 8'h00) begin
              cfg_rejected_q <= 1'b1; // R15
            end else if (PWDATA[`ERL_R_HORN] && !(PWDATA[`ERL_R_WARN] |
                         PWDATA[`ERL_R_SOFT] | PWDATA[`ERL_R_HARD])) begin
              cfg_rejected_q <= 1'b1; // R9
            end else begin
              cfg_q[sel_idx*8 +: 8] <= PWDATA[7:0];
            end
          end
          `ERL_A_TIMING:  timing_q  <= PWDATA[15:0];
          `ERL_A_RLY_MAP: rly_map_q <= PWDATA[7:0];
          default: ;
        endcase
      end
    end
  end

endmodule // erl_event_unit

//--- dv/erl_event_unit_chk.sv
/*
  Port checker for the event unit, bound to it at the foot of this file.
  Assumes a one-cycle APB answer, two cycles from events to outputs and one from links to LOG_VISIBLE.
*/
module erl_event_unit_chk (
  // Clock and reset
  input wire        CLOCK,
  input wire        RESET,
  // Bus
  input wire        PSEL,
  input wire        PENABLE,
  input wire [11:0] PADDR,
  input logic       PREADY,
  input logic       PSLVERR,
  // Events and links
  input wire [7:0]  EVENT_COND,
  input wire [6:0]  MODULE_ATTACHED,
  input wire [6:0]  MODULE_COMMUNICATING,
  // Outputs
  input logic       AMBER_LED,
  input logic       RED_LED,
  input logic       ENGINE_STOP,
  input logic       RESTART_INHIBIT,
  input logic [6:0] LOG_VISIBLE
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);
  sequence s_setup;
    PSEL && !PENABLE;
  endsequence
  // The first quiet cycle reaches AMBER_LED two cycles later, on the third
  sequence s_quiet;
    (EVENT_COND == 8'h00) [*3];
  endsequence
  a_ready_setup: assert property (s_setup |=> PREADY)
    else $error("ready missing after setup");
  a_ready_once: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  a_err_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  a_unmapped_err: assert property (s_setup ##0 (PADDR > 12'h01c) |=> PSLVERR)
    else $error("unmapped access not refused");
  a_log_vis: assert property (!$past(RESET) |-> LOG_VISIBLE ==
    ($past(MODULE_ATTACHED) & $past(MODULE_COMMUNICATING)))
    else $error("log visibility wrong");
  a_amber_cause: assert property (AMBER_LED |-> $past(EVENT_COND, 2) != 8'h00)
    else $error("amber without condition");
  a_quiet_amber: assert property (s_quiet |-> !AMBER_LED)
    else $error("amber with no event present");
  a_stop_inhibit: assert property (ENGINE_STOP |-> RESTART_INHIBIT)
    else $error("stop without restart inhibit");
  a_stop_red: assert property (ENGINE_STOP |-> RED_LED)
    else $error("stop without red indicator");
endmodule // erl_event_unit_chk

bind erl_event_unit erl_event_unit_chk u_erl_event_unit_chk (
  .CLOCK(CLOCK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .EVENT_COND(EVENT_COND),
  .MODULE_ATTACHED(MODULE_ATTACHED), .MODULE_COMMUNICATING(MODULE_COMMUNICATING),
  .AMBER_LED(AMBER_LED), .RED_LED(RED_LED), .ENGINE_STOP(ENGINE_STOP),
  .RESTART_INHIBIT(RESTART_INHIBIT), .LOG_VISIBLE(LOG_VISIBLE));

//--- dv/erl_far_side.sv
/*
  Model of the detectors, engine and expansion modules facing the unit.
  Assumes the bench calls its tasks; levels change just after an edge.
*/
module erl_far_side (
  // Clock
  input  logic       clock,
  // Detectors and engine
  output logic [7:0] cond,
  output logic       stop_sw,
  output logic       run,
  output logic       crank,
  // Expansion modules
  output logic [6:0] att,
  output logic [6:0] com
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ext_cond = 1'b0;
  logic ext_act = 1'b0;
  logic rst_all = 1'b0;
  initial {cond, stop_sw, run, crank, att, com} = '0;
  task automatic drive(input logic [7:0] c, input logic s, r, k);
    @(posedge clock);
    cond <= c;
    stop_sw <= s;
    run <= r;
    crank <= k;
  endtask
  task automatic link(input logic [6:0] a, m);
    @(posedge clock);
    att <= a;
    com <= m;
  endtask
  // A remote module keeps its own event; the unit never stores it
  always @(posedge clock) begin
    if (ext_cond) ext_act <= 1'b1;
    else if (rst_all) ext_act <= 1'b0;
  end
  task automatic remote(input logic v);
    @(posedge clock);
    ext_cond <= v;
  endtask
  task automatic reset_all();
    @(posedge clock);
    rst_all <= 1'b1;
    @(posedge clock);
    rst_all <= 1'b0;
  endtask
endmodule // erl_far_side

//--- dv/erl_event_unit_bench.sv
/*
  Self-checking bench of the event unit with a far-side model.
  Assumes a short tick so that timer counts stay brief.
*/
`include "erl_defs.vh"
module erl_event_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 10;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic        pready, pslverr, e, amber, red, estop, inhib, b1, b2, stop_sw, run, crank;
  logic [3:0]  relay;
  logic [6:0]  vis, att, com;
  logic [7:0]  cond;
  int          n_fail = 0;
  int          tests_run = 0;
  erl_event_unit #(.TICK_CYCLES(TK)) u_erl_event_unit (.CLOCK(clock), .RESET(reset),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .EVENT_COND(cond),
    .ENGINE_CONTROL_SWITCH_STOP(stop_sw), .ENGINE_RUNNING(run), .CRANK_TERMINATE(crank),
    .MODULE_ATTACHED(att), .MODULE_COMMUNICATING(com), .AMBER_LED(amber), .RED_LED(red),
    .RELAY_OUT(relay), .ENGINE_STOP(estop), .RESTART_INHIBIT(inhib),
    .BREAKER1_TRIP(b1), .BREAKER2_TRIP(b2), .LOG_VISIBLE(vis));
  erl_far_side u_erl_far_side (.clock(clock), .cond(cond), .stop_sw(stop_sw), .run(run),
    .crank(crank), .att(att), .com(com));
  always #20 clock = ~clock;
  task automatic chk(input string nm, input logic [31:0] s, x);
    tests_run++;
    if (s !== x) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) chk("ready wait", 0, 1);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, q, x);
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge clock);
  endtask
  task automatic t_regs();
    u_erl_far_side.drive(8'h00, 1'b1, 1'b0, 1'b0);
    rd(`ERL_A_TIMING, 32'h0a05, "timing");
    chk("mapped err", e, 0);
    apb(1'b1, `ERL_A_TIMING, 32'h0304);
    rd(`ERL_A_TIMING, 32'h0304, "timing write");
    apb(1'b1, `ERL_A_TIMING, 32'h0a05);
    rd(`ERL_A_CFG_SEL, 32'h0, "cfg sel");
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped err", e, 1);
    chk("unmapped data", q, 0);
    apb(1'b1, `ERL_A_CFG_DATA, 32'h00);
    rd(`ERL_A_CFG_DATA, 32'hc343, "view cfg");
    rd(`ERL_A_STATUS, 32'h21, "view status");
    apb(1'b1, `ERL_A_STATUS, 32'h30);
    apb(1'b1, `ERL_A_CFG_SEL, 32'h100);
    apb(1'b1, `ERL_A_CFG_DATA, 32'h04);
    rd(`ERL_A_STATUS, 32'h21, "subset status");
    rd(`ERL_A_CFG_DATA, 32'hc343, "subset cfg");
    apb(1'b1, `ERL_A_STATUS, 32'h30);
    apb(1'b1, `ERL_A_CFG_SEL, 32'h104);
    apb(1'b1, `ERL_A_CFG_DATA, 32'h02);
    rd(`ERL_A_STATUS, 32'h21, "horn status");
    apb(1'b1, `ERL_A_STATUS, 32'h30);
    apb(1'b1, `ERL_A_CFG_DATA, 32'h03);
    rd(`ERL_A_CFG_DATA, 32'hff03, "horn cfg");
  endtask
  task automatic t_warn();
    apb(1'b1, `ERL_A_RLY_MAP, 32'h41);
    rd(`ERL_A_RLY_MAP, 32'h41, "relay map");
    u_erl_far_side.drive(8'h01, 1'b1, 1'b0, 1'b0);
    wt(3);
    rd(`ERL_A_STATES, 32'h0, "gated state");
    u_erl_far_side.drive(8'h01, 1'b1, 1'b1, 1'b1);
    wt(50);
    chk("early amber", amber, 0);
    wt(80);
    rd(`ERL_A_STATES, 32'h1, "present");
    chk("amber", amber, 1);
    chk("horn", relay, 4'h9);
    chk("no stop", estop, 0);
    apb(1'b1, `ERL_A_RESET, 32'h1);
    apb(1'b0, `ERL_A_STATUS, 32'h0);
    chk("refused", q[4], 1);
    chk("timer expired", q[2], 1);
    apb(1'b1, `ERL_A_STATUS, 32'h30);
    u_erl_far_side.drive(8'h00, 1'b1, 1'b1, 1'b1);
    wt(3);
    rd(`ERL_A_STATES, 32'h3, "warn inactive");
    chk("history quiet", {inhib, amber, relay}, 0);
  endtask
  task automatic t_soft();
    int n;
    apb(1'b1, `ERL_A_CFG_SEL, 32'h102);
    u_erl_far_side.drive(8'h00, 1'b0, 1'b1, 1'b1);
    apb(1'b1, `ERL_A_CFG_DATA, 32'h04);
    rd(`ERL_A_CFG_DATA, 32'hfe0c, "run cfg");
    u_erl_far_side.drive(8'h00, 1'b1, 1'b1, 1'b1);
    apb(1'b1, `ERL_A_CFG_DATA, 32'h04);
    u_erl_far_side.drive(8'h04, 1'b0, 1'b1, 1'b1);
    wt(20);
    chk("red", red, 1);
    chk("cooldown", estop, 0);
    apb(1'b0, `ERL_A_STATUS, 32'h0);
    chk("cooling", q[3], 1);
    for (n = 0; n < 100 && estop !== 1'b1; n++) @(posedge clock);
    chk("soft stop", estop, 1);
    chk("cooldown span", n >= 20, 1);
    u_erl_far_side.drive(8'h00, 1'b0, 1'b0, 1'b0);
    wt(3);
    rd(`ERL_A_STATES, 32'h23, "latched");
    chk("inhibit", inhib, 1);
    apb(1'b1, `ERL_A_RESET, 32'h4);
    rd(`ERL_A_STATES, 32'h23, "run reset");
    u_erl_far_side.drive(8'h00, 1'b1, 1'b0, 1'b0);
    apb(1'b1, `ERL_A_RESET, 32'h4);
    wt(3);
    rd(`ERL_A_STATES, 32'h33, "reset done");
    chk("released", {inhib, estop, red}, 0);
  endtask
  task automatic t_hard();
    apb(1'b1, `ERL_A_RLY_MAP, 32'h38);
    apb(1'b1, `ERL_A_CFG_SEL, 32'h105);
    apb(1'b1, `ERL_A_CFG_DATA, 32'h30);
    apb(1'b1, `ERL_A_CFG_SEL, 32'h107);
    apb(1'b1, `ERL_A_CFG_DATA, 32'h80);
    u_erl_far_side.drive(8'ha8, 1'b1, 1'b1, 1'b1);
    wt(3);
    chk("hard stop", {estop, red}, 2'h3);
    chk("trips", {b2, b1, relay}, 6'h36);
    chk("info amber", amber, 0);
    rd(`ERL_A_STATES, 32'h4473, "all present");
    u_erl_far_side.drive(8'h00, 1'b1, 1'b0, 1'b0);
    wt(3);
    rd(`ERL_A_STATES, 32'h0cb3, "after clear");
    chk("trips off", {b2, b1, relay}, 0);
    apb(1'b1, `ERL_A_RESET, 32'h8);
    wt(3);
    chk("hard reset", {inhib, estop}, 0);
  endtask
  task automatic t_vis();
    u_erl_far_side.link(7'h5b, 7'h3e);
    wt(3);
    chk("log visible", vis, 7'h1a);
    rd(`ERL_A_LOG_VIS, 32'h1a, "log vis reg");
    u_erl_far_side.remote(1'b1);
    u_erl_far_side.reset_all();
    wt(1);
    chk("remote kept", u_erl_far_side.ext_act, 1);
    u_erl_far_side.remote(1'b0);
    u_erl_far_side.reset_all();
    wt(1);
    chk("remote reset", u_erl_far_side.ext_act, 0);
  endtask
  task automatic t_reset();
    @(posedge clock);
    reset <= 1'b1;
    wt(2);
    chk("reset vis", vis, 0);
    reset <= 1'b0;
    rd(`ERL_A_CFG_SEL, 32'h0, "reset view");
    rd(`ERL_A_CFG_DATA, 32'hc343, "reset cfg");
    rd(`ERL_A_STATES, 32'h0, "reset states");
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    t_regs();
    t_warn();
    t_soft();
    t_hard();
    t_vis();
    t_reset();
    report_and_stop();
  end
  // The scenarios need about four hundred cycles
  initial begin
    repeat (20000) @(posedge clock);
    chk("watchdog", 0, 1);
    report_and_stop();
  end
endmodule // erl_event_unit_bench
